/* pkg/msfl_pkg.sv */
package msfl_pkg;

  localparam int FW = 16;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PROT      = 8'h04;
  localparam logic [7:0] OFS_FREF      = 8'h08;
  localparam logic [7:0] OFS_FSTART    = 8'h0c;
  localparam logic [7:0] OFS_FMAX      = 8'h10;
  localparam logic [7:0] OFS_FBASE     = 8'h14;
  localparam logic [7:0] OFS_RAMP      = 8'h18;
  localparam logic [7:0] OFS_BRK_FREQ  = 8'h1c;
  localparam logic [7:0] OFS_BLOCK_T   = 8'h20;
  localparam logic [7:0] OFS_DC_DUR    = 8'h24;
  localparam logic [7:0] OFS_DC_PCT    = 8'h28;
  localparam logic [7:0] OFS_DWELL_F   = 8'h2c;
  localparam logic [7:0] OFS_DWELL_T   = 8'h30;
  localparam logic [7:0] OFS_STATUS    = 8'h34;
  localparam logic [7:0] OFS_INT_STAT  = 8'h38;
  localparam logic [7:0] OFS_INT_MASK  = 8'h3c;

  // ----------------------------------------------------------------
  // fields and mode codes
  // ----------------------------------------------------------------
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_MODE    = 1;
  localparam int CTRL_REACCEL = 4;
  localparam int PROT_STALL   = 3;
  localparam int INT_DONE     = 0;
  localparam int INT_BRAKE    = 1;
  localparam int INT_PBRK     = 2;
  localparam int INT_STALL    = 3;
  localparam int INT_W        = 4;

  localparam logic [2:0] MODE_DEC   = 3'h0;
  localparam logic [2:0] MODE_DCBRK = 3'h1;
  localparam logic [2:0] MODE_FREE  = 3'h2;
  localparam logic [2:0] MODE_PBRK  = 3'h4;

  // ----------------------------------------------------------------
  // ranges and reset values (0.01 Hz, 0.01 s, percent)
  // ----------------------------------------------------------------
  localparam logic [15:0] FSTART_MIN  = 16'h0001;
  localparam logic [15:0] FSTART_MAX  = 16'h03e8;
  localparam logic [15:0] FMAX_MIN    = 16'h0fa0;
  localparam logic [15:0] FMAX_MAX    = 16'h9c40;
  localparam logic [15:0] BRKF_MAX    = 16'h1770;
  localparam logic [15:0] TIME_MAX    = 16'h1770;
  localparam logic [15:0] PCT_MAX     = 16'h00c8;
  localparam logic [15:0] RST_FSTART  = 16'h0032;
  localparam logic [15:0] RST_FMAX    = 16'h1770;
  localparam logic [15:0] RST_FBASE   = 16'h1770;
  localparam logic [15:0] RST_BRKF    = 16'h01f4;
  localparam logic [15:0] RST_BLOCK_T = 16'h000a;
  localparam logic [15:0] RST_DC_DUR  = 16'h0064;
  localparam logic [15:0] RST_DC_PCT  = 16'h0032;
  localparam logic [15:0] RST_STEP    = 16'h000a;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 25000;
  localparam int TIME_UNIT_US   = 10000;
  localparam int RAMP_UNIT_US   = 1000;
  // cycles per microsecond first, so the product stays inside an int
  localparam int TICK_CYCLES    = TIME_UNIT_US * (1000000 / CLK_PERIOD_PS);
  localparam int RAMP_CYCLES    = RAMP_UNIT_US * (1000000 / CLK_PERIOD_PS);

  typedef enum logic [2:0] {
    ST_STOP  = 3'b000,
    ST_RUN   = 3'b001,
    ST_DECEL = 3'b010,
    ST_DWELL = 3'b011,
    ST_BLOCK = 3'b100,
    ST_DCINJ = 3'b101
  } msfl_state_t;

  function automatic logic [15:0] msfl_sat(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
    msfl_sat = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : msfl_sat

endpackage : msfl_pkg

/* rtl/msfl_freq_clamp.sv */
`timescale 1ns/1ps
module msfl_freq_clamp
  import msfl_pkg::*;
#(
  parameter bit FLOOR = 1'b1
)(
  input  wire logic [FW-1:0] value,
  input  wire logic [FW-1:0] start_freq,
  input  wire logic [FW-1:0] max_freq,
  output logic      [FW-1:0] clamped
);
  wire below_start = FLOOR && (value < start_freq);
  wire above_max   = value > max_freq;

  assign clamped = below_start ? '0 : (above_max ? max_freq : value);
endmodule : msfl_freq_clamp

/* rtl/msfl_interval_timer.sv */
`timescale 1ns/1ps
module msfl_interval_timer
  import msfl_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          start,
  input  wire logic          abort,
  input  wire logic          tick,
  input  wire logic [FW-1:0] length,
  output logic               expired
);
  logic [FW-1:0] remain;
  logic          active;

  // a zero length expires one cycle after start
  assign expired = active && (remain == '0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      remain <= '0;
      active <= 1'b0;
    end
    else if (abort)
      active <= 1'b0;
    else if (start)
    begin
      remain <= length;
      active <= 1'b1;
    end
    else if (expired)
      active <= 1'b0;
    else if (active && tick)
      remain <= remain - 16'h0001;
  end
endmodule : msfl_interval_timer

/* rtl/msfl_stop_seq.sv */
`timescale 1ns/1ps
module msfl_stop_seq
  import msfl_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int RAMP_CYC = RAMP_CYCLES
)(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          dc_link_over,
  input  wire logic          stall_overcurrent,
  output logic      [FW-1:0] out_freq,
  output logic               out_enable,
  output logic               dc_inject,
  output logic      [7:0]    dc_current_pct,
  output logic      [FW-1:0] base_freq,
  output logic               stall_active,
  output logic               pbrake_active,
  output logic               irq
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [4:0]       ctrl;
  logic [7:0]       prot;
  logic [FW-1:0]    freq_ref;
  logic [FW-1:0]    start_freq;
  logic [FW-1:0]    max_freq;
  logic [FW-1:0]    acc_step;
  logic [FW-1:0]    dec_step;
  logic [FW-1:0]    brk_freq;
  logic [FW-1:0]    block_t;
  logic [FW-1:0]    dc_dur;
  logic [7:0]       dc_pct;
  logic [FW-1:0]    dwell_f;
  logic [FW-1:0]    dwell_t;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_mask;

  msfl_state_t state;
  msfl_state_t next_state;
  logic        run_q;
  logic        brake_spent;
  logic        dwell_done;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup   = psel && !penable;
  wire wr      = psel && penable && pwrite;
  wire hit     = (paddr[1:0] == 2'b00) && (paddr <= OFS_INT_MASK);
  wire wr_ok   = wr && hit;
  wire [15:0] wlo = pwdata[15:0];
  wire [15:0] pct_sat = msfl_sat(wlo, 16'h0, PCT_MAX);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  wire [2:0] mode    = ctrl[CTRL_MODE +: 3];
  wire       run_cmd = ctrl[CTRL_RUN];
  wire       reaccel = ctrl[CTRL_REACCEL];
  wire       stall_en = prot[PROT_STALL];

  logic [31:0] rd_mux;
  always_comb
  begin
    case (paddr)
      OFS_CTRL:     rd_mux = {27'h0, ctrl};
      OFS_PROT:     rd_mux = {24'h0, prot};
      OFS_FREF:     rd_mux = {16'h0, freq_ref};
      OFS_FSTART:   rd_mux = {16'h0, start_freq};
      OFS_FMAX:     rd_mux = {16'h0, max_freq};
      OFS_FBASE:    rd_mux = {16'h0, base_freq};
      OFS_RAMP:     rd_mux = {dec_step, acc_step};
      OFS_BRK_FREQ: rd_mux = {16'h0, brk_freq};
      OFS_BLOCK_T:  rd_mux = {16'h0, block_t};
      OFS_DC_DUR:   rd_mux = {16'h0, dc_dur};
      OFS_DC_PCT:   rd_mux = {24'h0, dc_pct};
      OFS_DWELL_F:  rd_mux = {16'h0, dwell_f};
      OFS_DWELL_T:  rd_mux = {16'h0, dwell_t};
      OFS_STATUS:   rd_mux = {out_freq, 8'h0, pbrake_active,
                              stall_active, dc_inject, out_enable,
                              1'b0, state};
      OFS_INT_STAT: rd_mux = {28'h0, int_stat};
      OFS_INT_MASK: rd_mux = {28'h0, int_mask};
      default:      rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // configuration writes; start, max, braking entry, time and percent fields saturated to their range
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl       <= 5'h00;
      prot       <= 8'h00;
      freq_ref   <= 16'h0000;
      start_freq <= RST_FSTART;
      max_freq   <= RST_FMAX;
      base_freq  <= RST_FBASE;
      acc_step   <= RST_STEP;
      dec_step   <= RST_STEP;
      brk_freq   <= RST_BRKF;
      block_t    <= RST_BLOCK_T;
      dc_dur     <= RST_DC_DUR;
      dc_pct     <= RST_DC_PCT[7:0];
      dwell_f    <= 16'h0000;
      dwell_t    <= 16'h0000;
      int_mask   <= '0;
      prdata     <= 32'h0;
    end
    else
    begin
      if (setup)
        prdata <= rd_mux;
      if (wr_ok)
      begin
        case (paddr)
          OFS_CTRL:     ctrl <= pwdata[4:0];
          OFS_PROT:     prot <= pwdata[7:0];
          OFS_FREF:     freq_ref <= wlo;
          OFS_FSTART:   start_freq <= msfl_sat(wlo, FSTART_MIN,
                                               FSTART_MAX);
          OFS_FMAX:     max_freq <= msfl_sat(wlo, FMAX_MIN, FMAX_MAX);
          // base frequency takes any value, no ceiling applies
          OFS_FBASE:    base_freq <= wlo;
          OFS_RAMP:
          begin
            acc_step <= wlo;
            dec_step <= pwdata[31:16];
          end
          OFS_BRK_FREQ: brk_freq <= msfl_sat(wlo, 16'h0, BRKF_MAX);
          OFS_BLOCK_T:  block_t <= msfl_sat(wlo, 16'h0, TIME_MAX);
          OFS_DC_DUR:   dc_dur <= msfl_sat(wlo, 16'h0, TIME_MAX);
          OFS_DC_PCT:   dc_pct <= pct_sat[7:0];
          OFS_DWELL_F:  dwell_f <= wlo;
          OFS_DWELL_T:  dwell_t <= msfl_sat(wlo, 16'h0, TIME_MAX);
          OFS_INT_MASK: int_mask <= pwdata[INT_W-1:0];
          default:      ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers: three flops, a change counts once two agree
  // ----------------------------------------------------------------
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_f;
  wire  [1:0] pin_raw = {stall_overcurrent, dc_link_over};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
          pin_f[gi]  <= 1'b0;
        end
        else
        begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi])
            pin_f[gi] <= pin_s3[gi];
        end
      end
    end
  endgenerate

  wire vdc_over = pin_f[0];
  wire ovc      = pin_f[1];

  // ----------------------------------------------------------------
  // frequency clamps: reference, entry and dwell frequencies
  // ----------------------------------------------------------------
  logic [FW-1:0] clamp_in  [3];
  logic [FW-1:0] clamp_out [3];
  assign clamp_in[0] = freq_ref;
  assign clamp_in[1] = brk_freq;
  assign clamp_in[2] = dwell_f;

  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_clamp
      msfl_freq_clamp #(
        .FLOOR      (gi == 0)
      ) u_clamp (
        .value      (clamp_in[gi]),
        .start_freq (start_freq),
        .max_freq   (max_freq),
        .clamped    (clamp_out[gi])
      );
    end
  endgenerate

  wire [FW-1:0] target = clamp_out[0];
  wire [FW-1:0] brk_c  = clamp_out[1];
  wire [FW-1:0] dwl_c  = clamp_out[2];

  // ----------------------------------------------------------------
  // tick dividers: 10 ms timer unit, 1 ms ramp unit
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt;
  logic [31:0] ramp_cnt;
  wire tick      = tick_cnt == 32'(TICK_CYC - 1);
  wire ramp_tick = ramp_cnt == 32'(RAMP_CYC - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt <= 32'h0;
      ramp_cnt <= 32'h0;
    end
    else
    begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
      ramp_cnt <= ramp_tick ? 32'h0 : ramp_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // stop sequencer
  // ----------------------------------------------------------------
  logic tmr_exp;
  wire  run_rise  = run_cmd && !run_q;
  // braking entry only counts until injection has once completed
  wire  brk_reach = (mode == MODE_DCBRK) && !brake_spent
                    && (out_freq <= brk_c);
  // in dc braking mode, a dwell set under the entry frequency never runs
  wire  dwell_ok  = !((mode == MODE_DCBRK) && (dwl_c < brk_c))
                    && (dwell_t != '0) && !dwell_done;
  wire  dwell_hit = dwell_ok && (out_freq <= dwl_c) && (dwl_c != '0);
  // deceleration-only gating, power braking first
  wire  pb_now    = (state == ST_DECEL) && (mode == MODE_PBRK)
                    && vdc_over;
  wire  stall_now = (state == ST_DECEL) && stall_en && ovc
                    && !pb_now;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_STOP:
        if (run_rise)
          next_state = ST_RUN;
      ST_RUN:
        if (!run_cmd)
          next_state = (mode == MODE_FREE) ? ST_STOP
                                           : ST_DECEL;
      ST_DECEL:
        if (run_cmd)
          next_state = ST_RUN;
        else if (dwell_hit)
          next_state = ST_DWELL;
        else if (brk_reach)
          next_state = ST_BLOCK;
        else if (out_freq == '0)
          next_state = ST_STOP;
      ST_DWELL:
        if (run_cmd)
          next_state = ST_RUN;
        else if (tmr_exp)
          next_state = ST_DECEL;
      ST_BLOCK:
        if (run_cmd)
          next_state = ST_RUN;
        else if (tmr_exp)
          next_state = ST_DCINJ;
      ST_DCINJ:
        if (run_cmd)
          next_state = ST_RUN;
        else if (tmr_exp)
          next_state = ST_STOP;
      default:
        next_state = ST_STOP;
    endcase
  end

  wire entering  = next_state != state;
  wire tmr_start = entering && ((next_state == ST_DWELL)
                   || (next_state == ST_BLOCK) || (next_state == ST_DCINJ));
  wire [FW-1:0] tmr_len = (next_state == ST_DWELL) ? dwell_t :
                          (next_state == ST_BLOCK) ? block_t : dc_dur;

  msfl_interval_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tmr_start),
    .abort   (run_cmd),
    .tick    (tick),
    .length  (tmr_len),
    .expired (tmr_exp)
  );

  // ----------------------------------------------------------------
  // output frequency ramp
  // ----------------------------------------------------------------
  wire [16:0] up_sum   = {1'b0, out_freq} + {1'b0, acc_step};
  wire [FW-1:0] up_val = (up_sum > {1'b0, target}) ? target
                                                   : up_sum[FW-1:0];
  wire [FW-1:0] dn_run = (out_freq - target < acc_step) ? target
                                                : out_freq - acc_step;
  wire [FW-1:0] dn_dec = (out_freq < dec_step) ? 16'h0
                                               : out_freq - dec_step;
  wire [16:0] pb_sum   = {1'b0, out_freq} + {1'b0, acc_step};
  wire [FW-1:0] pb_val = (pb_sum > {1'b0, max_freq}) ? max_freq
                                                    : pb_sum[FW-1:0];
  logic [FW-1:0] next_freq;

  always_comb
  begin
    next_freq = out_freq;
    if ((next_state == ST_STOP) || (next_state == ST_BLOCK)
        || (next_state == ST_DCINJ))
      next_freq = '0;
    else if (entering && (state == ST_BLOCK || state == ST_DCINJ))
      next_freq = '0;
    else if (ramp_tick && state == ST_RUN)
      next_freq = (out_freq < target) ? up_val : dn_run;
    else if (ramp_tick && state == ST_DECEL)
    begin
      if (pb_now)
        next_freq = reaccel ? pb_val : out_freq;
      else if (!stall_now)
        next_freq = dn_dec;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state          <= ST_STOP;
      run_q          <= 1'b0;
      out_freq       <= '0;
      out_enable     <= 1'b0;
      dc_inject      <= 1'b0;
      dc_current_pct <= 8'h00;
      stall_active   <= 1'b0;
      pbrake_active  <= 1'b0;
      brake_spent    <= 1'b0;
      dwell_done     <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      run_q          <= run_cmd;
      out_freq       <= next_freq;
      out_enable     <= next_state inside {ST_RUN, ST_DECEL, ST_DWELL};
      dc_inject      <= next_state == ST_DCINJ;
      dc_current_pct <= (next_state == ST_DCINJ) ? dc_pct : 8'h00;
      stall_active   <= stall_now;
      pbrake_active  <= pb_now;
      if (run_rise)
      begin
        brake_spent <= 1'b0;
        dwell_done  <= 1'b0;
      end
      else
      begin
        if (state == ST_DCINJ && tmr_exp)
          brake_spent <= 1'b1;
        if (state == ST_DWELL && tmr_exp)
          dwell_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky, write one to clear, a new event wins
  // ----------------------------------------------------------------
  wire [INT_W-1:0] int_ev;
  assign int_ev[INT_DONE]  = entering && next_state == ST_STOP
                             && state != ST_RUN;
  assign int_ev[INT_BRAKE] = entering && next_state == ST_BLOCK;
  assign int_ev[INT_PBRK]  = pb_now && !pbrake_active;
  assign int_ev[INT_STALL] = stall_now && !stall_active;
  wire [INT_W-1:0] int_clr = (wr_ok && paddr == OFS_INT_STAT)
                             ? pwdata[INT_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_stat <= '0;
    else
      int_stat <= (int_stat & ~int_clr) | int_ev;
  end

  assign irq = |(int_stat & int_mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_dec_first: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == ST_DECEL) |-> $past(state) inside {ST_RUN, ST_DWELL})
    else $error("deceleration entered from wrong state");

  a_brk_entry: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_DECEL && next_state == ST_BLOCK)
    |-> mode == MODE_DCBRK && out_freq <= brk_c
    ##1 !out_enable && out_freq == '0)
    else $error("dc braking entered above entry frequency");

  a_blk_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_BLOCK |-> !out_enable && !dc_inject)
    else $error("output driven during block interval");

  a_dc_level: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_DCINJ |-> dc_inject && dc_current_pct == $past(dc_pct))
    else $error("dc level not the configured percent");

  a_free_run: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_RUN && !run_cmd && mode == MODE_FREE)
    |=> state == ST_STOP && !out_enable && out_freq == '0)
    else $error("free-run stop did not cut output");

  a_pb_decel: assert property (@(posedge pclk) disable iff (!presetn)
    (pbrake_active || stall_active) |-> $past(state) == ST_DECEL)
    else $error("braking aid active outside deceleration");

  a_pb_first: assert property (@(posedge pclk) disable iff (!presetn)
    pbrake_active |-> !stall_active)
    else $error("stall prevention ran beside power braking");

  a_ref_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (freq_ref < start_freq) |-> target == '0)
    else $error("reference below start not zero");

  a_ref_ceil: assert property (@(posedge pclk) disable iff (!presetn)
    target <= max_freq && brk_c <= max_freq)
    else $error("clamped frequency above maximum");

  a_dec_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_DECEL && mode == MODE_DEC && !run_cmd && !dwell_hit
     && out_freq == '0) |=> state == ST_STOP && !dc_inject)
    else $error("plain deceleration did not stop");

  a_inj_end: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_DCINJ && tmr_exp && !run_cmd)
    |=> state == ST_STOP && !dc_inject && int_stat[INT_DONE]
        && brake_spent)
    else $error("injection end not reported");

  a_run_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (state inside {ST_BLOCK, ST_DCINJ} && run_cmd)
    |=> state == ST_RUN && out_freq == '0)
    else $error("run did not abort braking");
endmodule : msfl_stop_seq

/* test/msfl_power_stage.sv */
`timescale 1ns/1ps
// power stage model: link overvoltage only while the bridge is switching
module msfl_power_stage (
  input  wire logic pclk,
  input  wire logic out_enable,
  input  wire logic ov_req,
  input  wire logic oc_req,
  output logic      dc_link_over,
  output logic      stall_overcurrent
);
  always_ff @(posedge pclk)
  begin
    dc_link_over      <= ov_req & out_enable;
    stall_overcurrent <= oc_req & out_enable;
  end
endmodule : msfl_power_stage

/* test/msfl_stop_seq_tb.sv */
`timescale 1ns/1ps
module msfl_stop_seq_tb;
  import msfl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic ov_req, oc_req, dc_link_over, stall_overcurrent, out_enable;
  logic dc_inject, stall_active, pbrake_active, se;
  logic [7:0] paddr, dc_current_pct, seen;
  logic [31:0] pwdata, prdata, rv;
  logic [FW-1:0] out_freq, base_freq;
  int fails, n_checks;
  msfl_stop_seq #(.TICK_CYC(400), .RAMP_CYC(40)) dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .dc_link_over, .stall_overcurrent, .out_freq, .out_enable, .dc_inject,
    .dc_current_pct, .base_freq, .stall_active, .pbrake_active, .irq);
  msfl_power_stage ps (.pclk, .out_enable, .ov_req, .oc_req, .dc_link_over,
    .stall_overcurrent);
  task stop_test;
    begin
      if (fails == 0 && n_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask : stop_test
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_checks++;
      if (seen !== exp)
      begin
        fails++;
        $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask : chk
  // one apb transfer; an idle edge follows so psel is never reassigned
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : xf
  task wst(input logic [2:0] s);
    int i;
    begin
      i = 0;
      do
      begin
        xf(0, OFS_STATUS, 0);
        seen[rv[2:0]] = 1'b1;
        i++;
      end
      while (i < 3000 && rv[2:0] !== s);
      chk(rv[2:0], s);
    end
  endtask : wst
  initial
  begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    repeat (50000) @(posedge pclk);
    fails++;
    stop_test;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, ov_req, oc_req} = 0;
    paddr = 0;
    pwdata = 0;
    rv = 0;
    seen = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(base_freq, RST_FBASE);
    xf(0, OFS_DC_PCT, 0);
    chk(rv, RST_DC_PCT);
    xf(1, OFS_RAMP, 32'h03e8_03e8);
    xf(1, OFS_BLOCK_T, 2);
    xf(1, OFS_DC_DUR, 2);
    xf(1, OFS_FREF, 40);
    xf(1, OFS_CTRL, 1);
    repeat (100) @(posedge pclk);
    chk(out_freq, 0);
    xf(1, OFS_FREF, 7000);
    repeat (400) @(posedge pclk);
    chk(out_freq, RST_FMAX);
    xf(1, OFS_FBASE, 8000);
    chk(base_freq, 8000);
    xf(1, OFS_DWELL_F, 100);
    xf(1, OFS_DWELL_T, 5);
    xf(1, OFS_CTRL, 2);
    wst(3'h4);
    chk(seen[3], 1'b0);
    chk(out_enable, 0);
    wst(3'h5);
    chk({dc_inject, dc_current_pct}, 9'h132);
    wst(3'h0);
    chk({irq, dc_inject, out_enable}, 0);
    xf(1, OFS_INT_MASK, 1);
    chk(irq, 1);
    xf(1, OFS_INT_STAT, 32'hf);
    chk(irq, 0);
    xf(1, OFS_CTRL, 3);
    repeat (400) @(posedge pclk);
    xf(1, OFS_CTRL, 2);
    wst(3'h4);
    xf(1, OFS_CTRL, 3);
    wst(3'h1);
    chk(rv[31:16], 0);
    xf(1, OFS_CTRL, 5);
    repeat (400) @(posedge pclk);
    xf(1, OFS_CTRL, 4);
    repeat (3) @(posedge pclk);
    chk(out_enable, 0);
    xf(1, OFS_CTRL, 1);
    repeat (400) @(posedge pclk);
    xf(1, OFS_CTRL, 0);
    seen = 8'h00;
    wst(3'h0);
    chk({out_freq, dc_inject}, 0);
    chk(seen[3], 1'b1);
    xf(1, OFS_PROT, 8);
    xf(1, OFS_CTRL, 9);
    ov_req <= 1'b1;
    oc_req <= 1'b1;
    repeat (400) @(posedge pclk);
    chk({pbrake_active, stall_active}, 0);
    xf(1, OFS_CTRL, 8);
    repeat (20) @(posedge pclk);
    chk({pbrake_active, stall_active}, 2'b10);
    chk(out_freq, RST_FMAX);
    xf(0, 8'h40, 0);
    chk(rv, 0);
    chk(se, 1'b1);
    stop_test;
  end
endmodule : msfl_stop_seq_tb
